// ==== core/slk_pkg.sv ====
// How it works
// - Lock bits protect only when select bit is 1
// - Select bit 0 uses complement, top/bottom, block field
// - Lock bits volatile, all set after any reset
// - Opcode 39h plus address clears one lock bit
// - Serial input sampled on rising clock edge
// - Opcode 3Dh plus address returns lock byte, MSB first
// - Returned byte LSB is 1 when locked
// - Host sends 32-bit address in four-byte mode
// - Opcode 7Eh alone sets every lock bit
// - Opcode 98h alone clears every lock bit
// - Accepted reset aborts work, clears volatile settings
// - Reset needs 66h then 99h back to back
// - Any other opcode after 66h disarms reset
// - Reset takes 30us, commands other than 3Dh rejected meanwhile
// - Host should check busy and suspend first
// - Opcode 36h plus address sets one lock bit
package slk_pkg;
	localparam logic [7:0] OP_LOCK    = 8'h36;
	localparam logic [7:0] OP_UNLOCK  = 8'h39;
	localparam logic [7:0] OP_RDLOCK  = 8'h3d;
	localparam logic [7:0] OP_GLOCK   = 8'h7e;
	localparam logic [7:0] OP_GUNLOCK = 8'h98;
	localparam logic [7:0] OP_RSTEN   = 8'h66;
	localparam logic [7:0] OP_RST     = 8'h99;

	localparam logic [5:0] OP_BITS   = 6'h08;
	localparam logic [5:0] ADDR3_END = 6'h20;
	localparam logic [5:0] ADDR4_END = 6'h28;
	localparam logic [5:0] RD_LAST   = 6'h07;
	localparam logic [5:0] CNT_MAX   = 6'h3f;

	localparam int         REGION_LSB = 16;
	localparam int         REGION_W   = 6;
	localparam int         LOCK_BITS  = 64;
	localparam logic [63:0] LOCK_RESET = 64'hffff_ffff_ffff_ffff;
	localparam logic [6:0] BP_SPAN_ALL = 7'h40;
	localparam logic [3:0] BP_FULL     = 4'h7;

	localparam int         RST_TIME_NS = 30000;
	localparam int         SYS_CLK_NS  = 10;
	localparam logic [11:0] RST_CYCLES =
		12'((RST_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
	localparam logic [11:0] CS_GAP     = 12'h004;
	localparam logic [3:0] SCLK_HALF   = 4'h5;

	typedef enum logic [1:0] {
		SLK_IDLE  = 2'b00,
		SLK_SHIFT = 2'b01,
		SLK_GAP   = 2'b10
	} slk_hst_t;

	function automatic logic [5:0] region_of(input logic [31:0] addr);
		region_of = addr[REGION_LSB +: REGION_W];
	endfunction
endpackage

// ==== core/slk_if.sv ====
`timescale 1ns/1ps
interface slk_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe;
	logic miso;

	// Released line reads as pulled high
	assign miso = so_oe ? so : 1'b1;

	modport host (
		output cs_n,
		output sclk,
		output si,
		input  miso
	);
	modport dev (
		input  cs_n,
		input  sclk,
		input  si,
		output so,
		output so_oe
	);
endinterface

// ==== core/slk_dev.sv ====
`timescale 1ns/1ps
module slk_dev
	import slk_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	slk_if.dev               link,
	input  wire logic        individual_protect_select_i,
	input  wire logic        protect_complement_i,
	input  wire logic        protect_top_bottom_i,
	input  wire logic [3:0]  block_protect_field_i,
	input  wire logic        four_byte_mode_i,
	input  wire logic        chk_valid_i,
	input  wire logic [31:0] chk_addr_i,
	output logic             chk_refuse_o,
	output logic             soft_reset_o,
	output logic             reset_busy_o,
	output logic             reset_armed_o,
	output logic [63:0]      lock_state_o
);
	// Link-clock side: shifts in the frame, serves lock reads
	logic        frame_reg;
	logic [5:0]  cnt_reg;
	logic [5:0]  cnt_next;
	logic [39:0] sh_reg;
	logic [39:0] sh_next;
	logic [7:0]  op_reg;
	logic        a4_meta_reg;
	logic        a4_reg;
	logic        rd_bit_reg;
	logic        so_reg;
	logic        so_oe_reg;

	// System side: executes commands at frame end
	logic        cs_meta_reg;
	logic        cs_sync_reg;
	logic        cs_last_reg;
	logic [63:0] lock_reg;
	logic [63:0] lock_next;
	logic        armed_reg;
	logic        armed_next;
	logic [11:0] busy_cnt_reg;
	logic [11:0] busy_cnt_next;
	logic        busy_reg;
	logic        soft_reg;
	logic        refuse_reg;

	wire [5:0] alen_link = a4_reg ? ADDR4_END : ADDR3_END;
	wire [5:0] rd_end    = 6'(alen_link + RD_LAST);
	wire       rd_cmd    = (op_reg == OP_RDLOCK);

	// Frame flag drops with chip select, so no edge is needed after a frame
	always_ff @(posedge link.sclk or posedge link.cs_n)
	begin
		if (link.cs_n)
			frame_reg <= 1'b0;
		else
			frame_reg <= 1'b1;
	end

	assign cnt_next = !frame_reg ? 6'h01 :
		(cnt_reg == CNT_MAX) ? cnt_reg : 6'(cnt_reg + 6'h01);
	assign sh_next = {frame_reg ? sh_reg[38:0] : 39'h0, link.si};

	always_ff @(posedge link.sclk or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_reg     <= 6'h00;
			sh_reg      <= 40'h0;
			op_reg      <= 8'h00;
			a4_meta_reg <= 1'b0;
			a4_reg      <= 1'b0;
			rd_bit_reg  <= 1'b1;
		end
		else
		begin
			cnt_reg     <= cnt_next;
			sh_reg      <= sh_next;
			a4_meta_reg <= four_byte_mode_i;
			a4_reg      <= a4_meta_reg;
			if (cnt_next == OP_BITS)
				op_reg <= sh_next[7:0];
			// Lock vector only moves between frames, so it is steady here
			if (cnt_next == alen_link)
				rd_bit_reg <= lock_reg[region_of(sh_next[31:0])];
		end
	end

	// Read data leaves on falling edges; only the last bit carries the lock
	always_ff @(negedge link.sclk or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			so_reg    <= 1'b0;
			so_oe_reg <= 1'b0;
		end
		else
		begin
			so_oe_reg <= rd_cmd && (cnt_reg >= alen_link);
			so_reg    <= rd_cmd && (cnt_reg == rd_end) && rd_bit_reg;
		end
	end

	assign link.so    = so_reg;
	assign link.so_oe = so_oe_reg;

	// Chip select reaches the system clock through two flops
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_last_reg <= 1'b1;
		end
		else
		begin
			cs_meta_reg <= link.cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_last_reg <= cs_sync_reg;
		end
	end

	// Frame words are held still while chip select is high
	wire       cs_rise   = cs_sync_reg && !cs_last_reg;
	wire [5:0] alen_sys  = four_byte_mode_i ? ADDR4_END : ADDR3_END;
	wire       bare_ok   = (cnt_reg == OP_BITS);
	wire       addr_ok   = (cnt_reg == alen_sys);
	wire       whole     = (cnt_reg >= OP_BITS);
	wire       exec      = cs_rise && whole && !busy_reg;
	wire [5:0] cmd_rgn   = region_of(sh_reg[31:0]);
	wire       rst_go    = exec && (op_reg == OP_RST) && bare_ok &&
		armed_reg;

	always_comb
	begin
		lock_next = lock_reg;
		if (rst_go)
			lock_next = LOCK_RESET;
		else if (exec)
		begin
			case (op_reg)
				OP_LOCK:
					if (addr_ok)
						lock_next[cmd_rgn] = 1'b1;
				OP_UNLOCK:
					if (addr_ok)
						lock_next[cmd_rgn] = 1'b0;
				OP_GLOCK:
					if (bare_ok)
						lock_next = LOCK_RESET;
				OP_GUNLOCK:
					if (bare_ok)
						lock_next = 64'h0;
				default:
					lock_next = lock_reg;
			endcase
		end
	end

	// Any finished frame other than a bare 66h disarms the reset
	assign armed_next = rst_go ? 1'b0 :
		exec ? ((op_reg == OP_RSTEN) && bare_ok) : armed_reg;

	assign busy_cnt_next = rst_go ? RST_CYCLES :
		(busy_cnt_reg != 12'h000) ? 12'(busy_cnt_reg - 12'h001) :
		busy_cnt_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lock_reg     <= LOCK_RESET;
			armed_reg    <= 1'b0;
			busy_cnt_reg <= 12'h000;
			busy_reg     <= 1'b0;
			soft_reg     <= 1'b0;
		end
		else
		begin
			lock_reg     <= lock_next;
			armed_reg    <= armed_next;
			busy_cnt_reg <= busy_cnt_next;
			busy_reg     <= (busy_cnt_next != 12'h000);
			soft_reg     <= rst_go;
		end
	end

	// Block-protect span in 64 KiB regions, counted from the chosen end
	wire [3:0] bp        = block_protect_field_i;
	wire [6:0] bp_span   = (bp == 4'h0) ? 7'h00 :
		(bp > BP_FULL) ? BP_SPAN_ALL : 7'(7'h01 << (bp - 4'h1));
	wire [5:0] chk_rgn   = region_of(chk_addr_i);
	wire       in_bottom = ({1'b0, chk_rgn} < bp_span);
	wire       in_top    = (7'(BP_SPAN_ALL - {1'b0, chk_rgn}) <= bp_span);
	wire       bp_hit    = protect_top_bottom_i ? in_bottom : in_top;
	wire       bp_prot   = bp_hit ^ protect_complement_i;
	wire       lk_prot   = lock_reg[chk_rgn];
	wire       prot      = individual_protect_select_i ? lk_prot
		: bp_prot;

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			refuse_reg <= 1'b0;
		else
			refuse_reg <= chk_valid_i && prot;
	end

	assign chk_refuse_o  = refuse_reg;
	assign soft_reset_o  = soft_reg;
	assign reset_busy_o  = busy_reg;
	assign reset_armed_o = armed_reg;
	assign lock_state_o  = lock_reg;
endmodule

// ==== core/slk_host.sv ====
`timescale 1ns/1ps
module slk_host
	import slk_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	slk_if.host              link,
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_op_i,
	input  wire logic [31:0] cmd_addr_i,
	input  wire logic        cmd_addr4_i,
	output logic             cmd_ready_o,
	output logic             done_o,
	output logic [7:0]       rdata_o
);
	slk_hst_t    state_reg;
	logic [3:0]  div_reg;
	logic        sclk_reg;
	logic        cs_n_reg;
	logic [47:0] tx_reg;
	logic [5:0]  left_reg;
	logic [7:0]  rx_reg;
	logic [7:0]  op_reg;
	logic [11:0] gap_reg;
	logic        armed_reg;
	logic        done_reg;
	logic [7:0]  rdata_reg;
	logic        mi_meta_reg;
	logic        mi_reg;

	wire        has_addr = (cmd_op_i == OP_LOCK) || (cmd_op_i == OP_UNLOCK)
		|| (cmd_op_i == OP_RDLOCK);
	wire        is_rd    = (cmd_op_i == OP_RDLOCK);
	wire [5:0]  alen     = cmd_addr4_i ? ADDR4_END : ADDR3_END;
	wire [5:0]  nbits    = !has_addr ? OP_BITS :
		is_rd ? 6'(alen + OP_BITS) : alen;
	wire [47:0] tx_load  = cmd_addr4_i ? {cmd_op_i, cmd_addr_i, 8'h00}
		: {cmd_op_i, cmd_addr_i[23:0], 16'h0000};
	wire        half     = (div_reg == 4'(SCLK_HALF - 4'h1));
	wire        start    = (state_reg == SLK_IDLE) && cmd_valid_i;
	wire        last_fall = (state_reg == SLK_SHIFT) && half && sclk_reg
		&& (left_reg == 6'h00);
	// Host side of the 30 us recovery wait after 66h then 99h
	wire [11:0] gap_load = ((op_reg == OP_RST) && armed_reg) ? RST_CYCLES
		: CS_GAP;

	assign cmd_ready_o = (state_reg == SLK_IDLE);

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mi_meta_reg <= 1'b1;
			mi_reg      <= 1'b1;
		end
		else
		begin
			mi_meta_reg <= link.miso;
			mi_reg      <= mi_meta_reg;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= SLK_IDLE;
			div_reg   <= 4'h0;
			sclk_reg  <= 1'b0;
			cs_n_reg  <= 1'b1;
			tx_reg    <= 48'h0;
			left_reg  <= 6'h00;
			rx_reg    <= 8'h00;
			op_reg    <= 8'h00;
			gap_reg   <= 12'h000;
			armed_reg <= 1'b0;
			done_reg  <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			done_reg <= last_fall;
			case (state_reg)
				SLK_IDLE:
					if (start)
					begin
						state_reg <= SLK_SHIFT;
						cs_n_reg  <= 1'b0;
						tx_reg    <= tx_load;
						left_reg  <= nbits;
						op_reg    <= cmd_op_i;
						div_reg   <= 4'h0;
					end
				SLK_SHIFT:
				begin
					div_reg <= half ? 4'h0 : 4'(div_reg + 4'h1);
					if (half && !sclk_reg)
					begin
						sclk_reg <= 1'b1;
						rx_reg   <= {rx_reg[6:0], mi_reg};
						left_reg <= 6'(left_reg - 6'h01);
					end
					else if (last_fall)
					begin
						sclk_reg  <= 1'b0;
						cs_n_reg  <= 1'b1;
						rdata_reg <= rx_reg;
						gap_reg   <= gap_load;
						armed_reg <= (op_reg == OP_RSTEN);
						state_reg <= SLK_GAP;
					end
					else if (half)
					begin
						sclk_reg <= 1'b0;
						tx_reg   <= {tx_reg[46:0], 1'b0};
					end
				end
				SLK_GAP:
				begin
					gap_reg <= 12'(gap_reg - 12'h001);
					if (gap_reg == 12'h001)
						state_reg <= SLK_IDLE;
				end
				default:
					state_reg <= SLK_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.si   = tx_reg[47];
	assign done_o    = done_reg;
	assign rdata_o   = rdata_reg;
endmodule

// ==== test/slk_link_chk.sv ====
`timescale 1ns/1ps
module slk_link_chk
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic si,
	input  wire logic so,
	input  wire logic so_oe,
	input  wire logic miso
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_high;
		sclk [*5];
	endsequence
	sequence s_lead;
		!sclk [*4];
	endsequence
	property p_half;
		$rose(sclk) |-> s_high ##1 !sclk;
	endproperty
	property p_si_hold;
		sclk && $past(sclk) |-> $stable(si);
	endproperty
	property p_idle;
		cs_n |-> !sclk;
	endproperty
	property p_start;
		$fell(cs_n) |-> s_lead;
	endproperty
	property p_gap;
		$rose(cs_n) |-> cs_n [*4];
	endproperty
	property p_oe_cs;
		so_oe |-> !cs_n;
	endproperty
	property p_oe_rise;
		$rose(so_oe) |-> $fell(sclk);
	endproperty
	// Output may move only on a falling link edge
	property p_so_hold;
		so_oe && $past(so_oe) && !$fell(sclk) |-> $stable(so);
	endproperty
	property p_lead_zero;
		$rose(so_oe) |-> !so [*8];
	endproperty
	// Released line must read as the pull-up level
	property p_rel_high;
		!so_oe |-> miso;
	endproperty
	a_half: assert property (p_half)
		else $error("link clock high time wrong");
	a_si_hold: assert property (p_si_hold)
		else $error("serial input moved while clock high");
	a_idle: assert property (p_idle)
		else $error("link clock high outside frame");
	a_start: assert property (p_start)
		else $error("clock too soon after select");
	a_gap: assert property (p_gap)
		else $error("frame gap too short");
	a_oe_cs: assert property (p_oe_cs)
		else $error("output driven while deselected");
	a_oe_rise: assert property (p_oe_rise)
		else $error("output enable off the falling edge");
	a_so_hold: assert property (p_so_hold)
		else $error("output changed between falling edges");
	a_lead_zero: assert property (p_lead_zero)
		else $error("lock byte upper bit not zero");
	a_rel_high: assert property (p_rel_high)
		else $error("released data line not high");
endmodule

// ==== test/sector_lock_and_soft_reset_test.sv ====
`timescale 1ns/1ps
module sector_lock_and_soft_reset_test
	import slk_pkg::*;
;
	typedef struct packed {
		logic [7:0]  op;
		logic [31:0] addr;
		logic [63:0] lock;
		logic [7:0]  rd;
	} slk_row_t;
	logic        sys_clk_i = 1'h0;
	logic        rst_i     = 1'h1;
	logic        cmd_valid = 1'h0;
	logic        cmd_addr4 = 1'h0;
	logic        fbm       = 1'h0;
	logic        chk_valid = 1'h0;
	logic [6:0]  prot_cfg  = 7'h00;
	logic [7:0]  cmd_op    = 8'h00;
	logic [7:0]  rd        = 8'h00;
	logic [31:0] cmd_addr  = 32'h0;
	logic [31:0] chk_addr  = 32'h0;
	logic        cmd_ready, done, refuse, soft_rst, busy, armed;
	logic [7:0]  rdata;
	logic [63:0] lock;
	int          error_cnt = 0;
	int          checks    = 0;
	int          busy_cnt  = 0;
	int          pulse_cnt = 0;
	slk_row_t    rows [9]  = '{
		'{OP_UNLOCK, 32'h0005_0000, 64'hffff_ffff_ffff_ffdf, 8'h00},
		'{OP_RDLOCK, 32'h0005_0000, 64'hffff_ffff_ffff_ffdf, 8'h00},
		'{OP_RDLOCK, 32'h0006_0000, 64'hffff_ffff_ffff_ffdf, 8'h01},
		'{OP_LOCK, 32'h0005_ffff, LOCK_RESET, 8'h00},
		'{OP_GUNLOCK, 32'h0, 64'h0, 8'h00},
		'{OP_RDLOCK, 32'h003f_0000, 64'h0, 8'h00},
		'{OP_LOCK, 32'h003f_0000, 64'h8000_0000_0000_0000, 8'h00},
		'{OP_RDLOCK, 32'h003f_1234, 64'h8000_0000_0000_0000, 8'h01},
		'{OP_GLOCK, 32'h0, LOCK_RESET, 8'h00}
	};

	slk_if lnk();
	slk_host i_slk_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(lnk),
		.cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
		.cmd_addr4_i(cmd_addr4), .cmd_ready_o(cmd_ready), .done_o(done),
		.rdata_o(rdata));
	slk_dev i_slk_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(lnk),
		.individual_protect_select_i(prot_cfg[6]),
		.protect_complement_i(prot_cfg[5]),
		.protect_top_bottom_i(prot_cfg[4]),
		.block_protect_field_i(prot_cfg[3:0]), .four_byte_mode_i(fbm),
		.chk_valid_i(chk_valid), .chk_addr_i(chk_addr),
		.chk_refuse_o(refuse), .soft_reset_o(soft_rst),
		.reset_busy_o(busy), .reset_armed_o(armed), .lock_state_o(lock));
	slk_link_chk i_slk_link_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so),
		.so_oe(lnk.so_oe), .miso(lnk.miso));

	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		busy_cnt += int'(busy === 1'h1);
		pulse_cnt += int'(soft_rst === 1'h1);
	end

	task give_verdict;
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task bound(input int n);
		if (n >= 1000)
		begin
			error_cnt++;
			give_verdict;
		end
	endtask
	task send(input logic [7:0] op, input logic [31:0] a, input logic a4);
		int n;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 1000)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		bound(n);
		@(posedge sys_clk_i);
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_addr4 <= a4;
		@(posedge sys_clk_i);
		cmd_valid <= 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 1000)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		bound(n);
		rd = rdata;
		// Covers frame gap and the sync into the core
		repeat (8) @(posedge sys_clk_i);
	endtask
	task probe(input logic [6:0] cfg, input logic [31:0] a);
		@(posedge sys_clk_i);
		prot_cfg <= cfg;
		chk_valid <= 1'h1;
		chk_addr <= a;
		@(posedge sys_clk_i);
		chk_valid <= 1'h0;
		#1;
	endtask

	initial
	begin
		int n;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		@(negedge sys_clk_i);
		check(lock, LOCK_RESET);
		foreach (rows[i])
		begin
			send(rows[i].op, rows[i].addr, 1'h0);
			check(lock, rows[i].lock);
			if (rows[i].op == OP_RDLOCK)
				check(rd, rows[i].rd);
		end
		fbm <= 1'h1;
		send(OP_UNLOCK, 32'h0103_0000, 1'h1);
		check(lock, 64'hffff_ffff_ffff_fff7);
		// Short address in four-byte mode must be ignored
		send(OP_LOCK, 32'h0003_0000, 1'h0);
		check(lock, 64'hffff_ffff_ffff_fff7);
		send(OP_RDLOCK, 32'h0103_0000, 1'h1);
		check(rd, 8'h00);
		fbm <= 1'h0;
		probe(7'h40, 32'h0003_0000);
		check(refuse, 1'h0);
		probe(7'h40, 32'h0004_0000);
		check(refuse, 1'h1);
		probe(7'h00, 32'h0004_0000);
		check(refuse, 1'h0);
		probe(7'h08, 32'h0003_0000);
		check(refuse, 1'h1);
		probe(7'h20, 32'h0003_0000);
		check(refuse, 1'h1);
		probe(7'h11, 32'h0000_0000);
		check(refuse, 1'h1);
		probe(7'h11, 32'h003f_0000);
		check(refuse, 1'h0);
		probe(7'h01, 32'h003f_0000);
		check(refuse, 1'h1);
		send(OP_GUNLOCK, 32'h0, 1'h0);
		send(OP_RSTEN, 32'h0, 1'h0);
		check(armed, 1'h1);
		send(OP_RDLOCK, 32'h0, 1'h0);
		check(armed, 1'h0);
		send(OP_RST, 32'h0, 1'h0);
		check(pulse_cnt, 0);
		check(busy, 1'h0);
		send(OP_RSTEN, 32'h0, 1'h0);
		send(OP_RST, 32'h0, 1'h0);
		check(pulse_cnt, 1);
		check(lock, LOCK_RESET);
		check(busy, 1'h1);
		// Host itself holds off for the whole recovery time
		check(cmd_ready, 1'h0);
		repeat (1000) @(posedge sys_clk_i);
		check(cmd_ready, 1'h0);
		check(lock, LOCK_RESET);
		n = 0;
		while (busy === 1'h1 && n < 1000)
		begin
			repeat (4) @(posedge sys_clk_i);
			n++;
		end
		bound(n);
		check(busy_cnt, RST_CYCLES);
		send(OP_GUNLOCK, 32'h0, 1'h0);
		check(lock, 64'h0);
		@(posedge sys_clk_i);
		rst_i <= 1'h1;
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		@(negedge sys_clk_i);
		check(lock, LOCK_RESET);
		give_verdict;
	end
endmodule
